// ---- rtl/link_test_pkg.sv ----
// constants and types shared by the serial link test pattern generator
// assumes an 8b/10b or 64b/66b encoder downstream of the lane octet outputs
package link_test_pkg;

    typedef enum logic [2:0] {
        TM_OFF,
        TM_TRANSPORT,
        TM_D21_5,
        TM_K28_5,
        TM_REP_ILA,
        TM_RPAT
    } test_mode_e;

    typedef enum logic [1:0] {
        VAR_SINGLE,
        VAR_DUAL,
        VAR_QUAD
    } variant_e;

    typedef enum logic {
        ILA_CGS,
        ILA_SEQ
    } ila_e;

    localparam int STREAMS = 8;
    localparam int SMP_W   = 12;

    localparam logic [3:0] FMT_13 = 4'hD;
    localparam logic [3:0] FMT_14 = 4'hE;
    localparam logic [3:0] FMT_15 = 4'hF;

    localparam logic [2:0] SPF_FMT13 = 3'h4;
    localparam logic [2:0] SPF_FMT14 = 3'h2;

    localparam logic [7:0] OCT_D21_5 = 8'hB5;
    localparam logic [7:0] OCT_K28_5 = 8'hBC;
    localparam logic [7:0] OCT_K28_0 = 8'h1C;
    localparam logic [7:0] OCT_K28_3 = 8'h7C;

    localparam logic [3:0] RPAT_LAST = 4'hB;
    localparam logic [7:0] RPAT_OCT [12] = '{
        8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
        8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59
    };

    localparam logic [1:0] ILA_MF_LAST = 2'h3;

endpackage

// ---- rtl/transport_pattern.sv ----
// short transport sample patterns for link format modes 13, 14 and 15
// assumes the caller registers the result and steps sample_idx per sample
`timescale 1ns/100ps
module transport_pattern
    import link_test_pkg::*;
(
    input  wire logic [3:0]               link_format_mode,
    input  variant_e                      variant,
    input  wire logic [1:0]               sample_idx,
    output logic [STREAMS*SMP_W-1:0]      pattern,
    output logic [STREAMS-1:0]            present,
    output logic [2:0]                    frame_len
);

    always_comb begin
        case (link_format_mode)
            FMT_13:  frame_len = SPF_FMT13;
            FMT_14:  frame_len = SPF_FMT14;
            FMT_15:  frame_len = SPF_FMT14;
            default: frame_len = 3'h0;
        endcase
    end

    for (genvar s = 0; s < STREAMS; s++) begin : g_stream
        localparam logic [3:0] TOP13 = 4'(3 - (s % 4));
        localparam logic [3:0] TOP14 = 4'(15 - s);
        localparam logic [3:0] MID   = 4'(s);
        logic [3:0] low;
        assign low = {2'h0, sample_idx} + 4'h1;
        always_comb begin
            pattern[s*SMP_W +: SMP_W] = 12'h000;
            present[s] = 1'b0;
            case (link_format_mode)
                FMT_13: begin
                    pattern[s*SMP_W +: SMP_W] = {TOP13, MID, low};
                    present[s] = (s < 4) || (variant == VAR_DUAL);
                end
                FMT_14: begin
                    pattern[s*SMP_W +: SMP_W] = {TOP14, MID, low};
                    present[s] = (s < 2) || (variant == VAR_QUAD)
                        || ((s < 4) && (variant != VAR_SINGLE));
                end
                FMT_15: begin
                    pattern[s*SMP_W +: SMP_W] = {TOP14, MID, low};
                    present[s] = (s < 4) || (variant == VAR_DUAL);
                end
                default: begin
                    present[s] = 1'b0;
                end
            endcase
        end
    end

endmodule // transport_pattern

// ---- rtl/link_test_gen.sv ----
// test pattern source in the transmit path of a multi-lane serial link
// assumes frame_tick marks frame starts and lane octets feed the encoder
`timescale 1ns/100ps
module link_test_gen
    import link_test_pkg::*;
#(
    parameter int LANES     = 8,
    parameter int MF_OCTETS = 32
)
(
    input  wire logic                     clock,
    input  wire logic                     nrst,
    input  test_mode_e                    test_mode,
    input  wire logic [3:0]               link_format_mode,
    input  variant_e                      variant,
    input  wire logic                     enc_64b66b,
    input  wire logic                     frame_tick,
    input  wire logic                     sync_n,
    input  wire logic [STREAMS*SMP_W-1:0] conv_sample,
    input  wire logic [STREAMS-1:0]       conv_valid,
    input  wire logic [LANES*8-1:0]       link_octet_in,
    input  wire logic [LANES-1:0]         link_k_in,
    output logic [STREAMS*SMP_W-1:0]      sample_out,
    output logic [STREAMS-1:0]            sample_valid,
    output logic [LANES*8-1:0]            lane_octet,
    output logic [LANES-1:0]              lane_k,
    output logic                          ila_running
);

    localparam int MPOS_W = $clog2(MF_OCTETS);
    localparam logic [MPOS_W-1:0] MPOS_LAST = MPOS_W'(MF_OCTETS - 1);

    typedef struct packed {
        test_mode_e                 mode;
        logic                       enc64;
        logic [3:0]                 fmt;
        variant_e                   vart;
        logic [1:0]                 sidx;
        logic [3:0]                 ridx;
        ila_e                       ila;
        logic [MPOS_W-1:0]          mpos;
        logic [1:0]                 mfc;
        logic [STREAMS*SMP_W-1:0]   smp;
        logic [STREAMS-1:0]         sval;
        logic [LANES*8-1:0]         oct;
        logic [LANES-1:0]           kch;
        logic                       ilar;
    } state_s;

    state_s     st_q;
    state_s     st_d;
    test_mode_e eff_mode;
    logic [STREAMS*SMP_W-1:0] pat;
    logic [STREAMS-1:0]       pat_present;
    logic [2:0]               pat_len;
    logic [2:0]               sidx_inc;

    transport_pattern u_pattern (
        .link_format_mode (st_q.fmt),
        .variant          (st_q.vart),
        .sample_idx       (st_q.sidx),
        .pattern          (pat),
        .present          (pat_present),
        .frame_len        (pat_len)
    );

    // character modes that need 8b/10b fall back to normal data otherwise
    always_comb begin
        eff_mode = st_q.mode;
        if (st_q.enc64 && (st_q.mode == TM_K28_5 || st_q.mode == TM_REP_ILA
                || st_q.mode == TM_RPAT)) begin
            eff_mode = TM_OFF;
        end
        if (st_q.mode == TM_TRANSPORT && pat_len == 3'h0) begin
            eff_mode = TM_OFF;
        end
    end

    assign sidx_inc = {1'b0, st_q.sidx} + 3'h1;

    always_comb begin
        st_d = st_q;
        // setting is taken only on a frame boundary
        if (frame_tick) begin
            st_d.mode  = test_mode;
            st_d.enc64 = enc_64b66b;
            st_d.fmt   = link_format_mode;
            st_d.vart  = variant;
            st_d.sidx  = 2'h0;
            if (test_mode != st_q.mode) begin
                st_d.ridx = 4'h0;
                st_d.ila  = ILA_CGS;
                st_d.mpos = '0;
                st_d.mfc  = 2'h0;
            end
        end else begin
            st_d.sidx = (sidx_inc == pat_len) ? 2'h0 : sidx_inc[1:0];
        end

        if (eff_mode == TM_TRANSPORT) begin
            st_d.smp  = pat;
            st_d.sval = pat_present;
        end else begin
            st_d.smp  = conv_sample;
            st_d.sval = conv_valid;
        end

        st_d.ilar = 1'b0;
        case (eff_mode)
            TM_D21_5: begin
                st_d.oct = {LANES{OCT_D21_5}};
                st_d.kch = '0;
            end
            TM_K28_5: begin
                st_d.oct = {LANES{OCT_K28_5}};
                st_d.kch = '1;
            end
            TM_RPAT: begin
                st_d.oct = {LANES{RPAT_OCT[st_q.ridx]}};
                st_d.kch = '0;
                if (!(frame_tick && test_mode != st_q.mode)) begin
                    st_d.ridx = (st_q.ridx == RPAT_LAST) ? 4'h0
                        : st_q.ridx + 4'h1;
                end
            end
            TM_REP_ILA: begin
                if (st_q.ila == ILA_CGS) begin
                    st_d.oct = {LANES{OCT_K28_5}};
                    st_d.kch = '1;
                    if (sync_n && frame_tick) begin
                        st_d.ila  = ILA_SEQ;
                        st_d.mpos = '0;
                        st_d.mfc  = 2'h0;
                    end
                end else begin
                    st_d.ilar = 1'b1;
                    if (st_q.mpos == '0) begin
                        st_d.oct = {LANES{OCT_K28_0}};
                        st_d.kch = '1;
                    end else if (st_q.mpos == MPOS_LAST) begin
                        st_d.oct = {LANES{OCT_K28_3}};
                        st_d.kch = '1;
                    end else begin
                        st_d.oct = {LANES{8'(st_q.mpos)}};
                        st_d.kch = '0;
                    end
                    st_d.mpos = (st_q.mpos == MPOS_LAST) ? '0
                        : st_q.mpos + MPOS_W'(1);
                    // after the last multiframe start over, never data
                    if (st_q.mpos == MPOS_LAST) begin
                        st_d.mfc = (st_q.mfc == ILA_MF_LAST) ? 2'h0
                            : st_q.mfc + 2'h1;
                    end
                end
                if (!sync_n) begin
                    st_d.ila = ILA_CGS;
                end
            end
            default: begin
                st_d.oct = link_octet_in;
                st_d.kch = link_k_in;
            end
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign sample_out   = st_q.smp;
    assign sample_valid = st_q.sval;
    assign lane_octet   = st_q.oct;
    assign lane_k       = st_q.kch;
    assign ila_running  = st_q.ilar;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_d215_lanes: assert property (eff_mode == TM_D21_5
        |=> lane_octet == {LANES{OCT_D21_5}} && lane_k == '0)
        else $error("d21.5 lanes wrong");
    a_k285_lanes: assert property (eff_mode == TM_K28_5
        |=> lane_octet == {LANES{OCT_K28_5}} && lane_k == '1)
        else $error("k28.5 lanes wrong");
    a_k285_only_8b: assert property (st_q.mode == TM_K28_5 && st_q.enc64
        |=> lane_octet == $past(link_octet_in))
        else $error("k28.5 sent under 64b66b");
    a_rpat_wrap: assert property (eff_mode == TM_RPAT
        && st_q.ridx == RPAT_LAST && !frame_tick
        |=> lane_octet[7:0] == 8'h59 && st_q.ridx == 4'h0)
        else $error("rpat wrap wrong");
    a_rpat_pair: assert property ((eff_mode == TM_RPAT && st_q.ridx == 4'h0
        && !frame_tick) ##1 (eff_mode == TM_RPAT && !frame_tick)
        |-> lane_octet[7:0] == 8'hBE ##1 lane_octet[7:0] == 8'hD7)
        else $error("rpat first pair wrong");
    a_cgs_reply: assert property (eff_mode == TM_REP_ILA && !sync_n
        && !frame_tick
        |=> st_q.ila == ILA_CGS ##1 lane_octet[7:0] == OCT_K28_5
            && lane_k[0])
        else $error("sync request not answered");
    a_ila_mf_start: assert property (eff_mode == TM_REP_ILA
        && st_q.ila == ILA_SEQ && st_q.mpos == '0
        |=> lane_k[0] && lane_octet[7:0] == OCT_K28_0 && ila_running)
        else $error("multiframe start missing");
    a_fmt13_first: assert property (eff_mode == TM_TRANSPORT
        && st_q.fmt == FMT_13 && st_q.sidx == 2'h0
        |=> sample_out[SMP_W-1:0] == 12'h301 && sample_valid[0])
        else $error("mode 13 sample wrong");
    a_fmt14_last: assert property (eff_mode == TM_TRANSPORT
        && st_q.fmt == FMT_14 && st_q.vart == VAR_QUAD && st_q.sidx == 2'h1
        |=> sample_out[7*SMP_W +: SMP_W] == 12'h872 && sample_valid[7])
        else $error("mode 14 sample wrong");
    a_fmt15_first: assert property (eff_mode == TM_TRANSPORT
        && st_q.fmt == FMT_15 && st_q.sidx == 2'h0
        |=> sample_out[SMP_W-1:0] == 12'hF01 && ((!sample_valid[4])
            == ($past(st_q.vart) != VAR_DUAL)))
        else $error("mode 15 sample wrong");
    a_frame_wrap: assert property (eff_mode == TM_TRANSPORT
        && st_q.fmt == FMT_13 && st_q.sidx == 2'h3 && !frame_tick
        |=> st_q.sidx == 2'h0)
        else $error("frame does not repeat");
    a_mode_hold: assert property (!frame_tick |=> $stable(st_q.mode))
        else $error("mode changed off boundary");
    a_normal_pass: assert property (eff_mode == TM_OFF
        |=> sample_out == $past(conv_sample))
        else $error("normal data not passed");

    c_rpat_loop: cover property (eff_mode == TM_RPAT
        && st_q.ridx == RPAT_LAST);
    c_ila_seq: cover property (eff_mode == TM_REP_ILA
        && st_q.ila == ILA_SEQ && st_q.mfc == ILA_MF_LAST);
    c_fmt14: cover property (eff_mode == TM_TRANSPORT
        && st_q.fmt == FMT_14);

endmodule // link_test_gen

// ---- test/sync_rx.sv ----
// link receiver model: raises its sync request until it has seen commas
// assumes lane outputs are settled at the falling clock edge
`timescale 1ns/100ps
module sync_rx
    import link_test_pkg::*;
#(
    parameter int LANES    = 8,
    parameter int CGS_NEED = 4
)
(
    input  wire logic               clock,
    input  wire logic               nrst,
    input  wire logic [LANES*8-1:0] lane_octet,
    input  wire logic [LANES-1:0]   lane_k,
    input  wire logic               resync,
    output logic                    sync_n
);
    int k_cnt;
    always @(negedge clock or negedge nrst) begin
        if (!nrst || resync) begin
            k_cnt  <= 0;
            sync_n <= 1'b0;
        end else if (!sync_n) begin
            if (lane_octet === {LANES{OCT_K28_5}} && lane_k === '1)
                k_cnt <= k_cnt + 1;
            else
                k_cnt <= 0;
            if (k_cnt >= CGS_NEED)
                sync_n <= 1'b1;
        end
    end
endmodule // sync_rx

// ---- test/tb.sv ----
// self-checking bench for the link test pattern generator
// assumes one clock domain, inputs driven just after the falling edge
`timescale 1ns/100ps
module tb;
    import link_test_pkg::*;
    localparam int LANES = 8;
    localparam int MF    = 8;
    logic clock = 0, nrst = 0, frame_tick = 0, enc_64b66b = 0, resync = 0;
    test_mode_e test_mode = TM_OFF;
    variant_e variant = VAR_SINGLE;
    logic [3:0] link_format_mode = FMT_13;
    logic [95:0] conv_sample = '0, sample_out, p_smp;
    logic [7:0] conv_valid = '0, sample_valid, p_val;
    logic [63:0] link_octet_in = '0, lane_octet, p_oct;
    logic [7:0] link_k_in = '0, lane_k, p_k;
    logic sync_n, ila_running;
    logic [12:0] e;
    logic [3:0] fmt_t [7] = '{FMT_13, FMT_13, FMT_14, FMT_14, FMT_14,
                              FMT_15, FMT_15};
    variant_e var_t [7] = '{VAR_DUAL, VAR_SINGLE, VAR_QUAD, VAR_DUAL,
                            VAR_SINGLE, VAR_DUAL, VAR_SINGLE};
    test_mode_e fb_t [3] = '{TM_K28_5, TM_REP_ILA, TM_RPAT};
    int n_errors = 0, samples_checked = 0, n;

    always #25 clock = ~clock;

    link_test_gen #(.LANES(LANES), .MF_OCTETS(MF)) i_link_test_gen (
        .clock(clock), .nrst(nrst), .test_mode(test_mode),
        .link_format_mode(link_format_mode), .variant(variant),
        .enc_64b66b(enc_64b66b), .frame_tick(frame_tick), .sync_n(sync_n),
        .conv_sample(conv_sample), .conv_valid(conv_valid),
        .link_octet_in(link_octet_in), .link_k_in(link_k_in),
        .sample_out(sample_out), .sample_valid(sample_valid),
        .lane_octet(lane_octet), .lane_k(lane_k), .ila_running(ila_running));
    sync_rx #(.LANES(LANES)) i_sync_rx (.clock(clock), .nrst(nrst),
        .lane_octet(lane_octet), .lane_k(lane_k), .resync(resync),
        .sync_n(sync_n));

    // random normal traffic; p_ holds what the last rising edge took
    task automatic rand_drive;
        forever begin
            @(negedge clock);
            p_smp = conv_sample; p_val = conv_valid;
            p_oct = link_octet_in; p_k = link_k_in;
            conv_sample = {$urandom, $urandom, $urandom};
            conv_valid = 8'($urandom);
            link_octet_in = {$urandom, $urandom};
            link_k_in = 8'($urandom);
        end
    endtask

    task automatic step;
        @(negedge clock);
        #1;
    endtask
    task automatic set_mode(test_mode_e m, logic [3:0] f, variant_e v,
                            logic c);
        step;
        test_mode = m; link_format_mode = f; variant = v; enc_64b66b = c;
        frame_tick = 1'b1;
        step;
        frame_tick = 1'b0;
        step;
    endtask
    task automatic fail(logic [175:0] g, logic [175:0] x);
        n_errors++;
        $display("ERROR t=%0t got %h exp %h", $time, g, x);
    endtask
    task automatic chk_lane(logic [7:0] o, logic k);
        samples_checked++;
        if (lane_octet !== {LANES{o}} || lane_k !== {LANES{k}})
            fail({lane_octet, lane_k}, {{LANES{o}}, {LANES{k}}});
    endtask
    task automatic chk_val(logic [11:0] g, logic [11:0] x);
        samples_checked++;
        if (g !== x) fail(g, x);
    endtask
    task automatic chk_pass;
        samples_checked++;
        if ({lane_octet, lane_k, sample_out, sample_valid} !==
            {p_oct, p_k, p_smp, p_val})
            fail({lane_octet, lane_k, sample_out, sample_valid},
                 {p_oct, p_k, p_smp, p_val});
    endtask
    function automatic logic [12:0] exp_smp(logic [3:0] f, variant_e v,
                                            int s, int i);
        logic pres;
        logic [3:0] top;
        top = (f == FMT_13) ? 4'(3 - s % 4) : 4'(15 - s);
        if (f == FMT_14)
            pres = s < 2 || (s < 4 && v != VAR_SINGLE) || v == VAR_QUAD;
        else
            pres = s < 4 || v == VAR_DUAL;
        return {pres, top, 4'(s), 4'(i + 1)};
    endfunction
    task automatic results;
        if (n_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        #(50 * 3000);
        n_errors++;
        results;
    end

    initial begin
        void'($urandom(87));
        fork
            rand_drive;
        join_none
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        for (int t = 0; t < 7; t++) begin
            set_mode(TM_TRANSPORT, fmt_t[t], var_t[t], 1'b0);
            for (int j = 0; j < 8; j++) begin
                for (int s = 0; s < 8; s++) begin
                    e = exp_smp(fmt_t[t], var_t[t], s,
                                j % (fmt_t[t] == FMT_13 ? 4 : 2));
                    chk_val(12'(sample_valid[s]), 12'(e[12]));
                    if (e[12])
                        chk_val(sample_out[s*12+:12], e[11:0]);
                end
                step;
            end
        end
        set_mode(TM_TRANSPORT, 4'h3, VAR_QUAD, 1'b0);
        repeat (3) begin step; chk_pass; end
        set_mode(TM_OFF, FMT_13, VAR_QUAD, 1'b0);
        repeat (5) begin step; chk_pass; end
        for (int c = 0; c < 2; c++) begin
            set_mode(TM_D21_5, FMT_14, VAR_DUAL, 1'(c));
            repeat (3) begin step; chk_lane(OCT_D21_5, 1'b0); end
        end
        test_mode = TM_K28_5;
        repeat (3) begin step; chk_lane(OCT_D21_5, 1'b0); end
        set_mode(TM_K28_5, FMT_14, VAR_DUAL, 1'b0);
        repeat (6) begin step; chk_lane(OCT_K28_5, 1'b1); end
        set_mode(TM_RPAT, FMT_14, VAR_DUAL, 1'b0);
        resync = 1'b1;
        for (int j = 0; j < 26; j++) begin
            chk_lane(RPAT_OCT[j % 12], 1'b0);
            step;
            resync = 1'b0;
        end
        set_mode(TM_REP_ILA, FMT_14, VAR_DUAL, 1'b0);
        repeat (3) begin step; chk_lane(OCT_K28_5, 1'b1); end
        chk_val(12'(ila_running), 12'h000);
        for (n = 0; n < 20 && sync_n !== 1'b1; n++) step;
        set_mode(TM_REP_ILA, FMT_14, VAR_DUAL, 1'b0);
        for (n = 0; n < 10 && ila_running !== 1'b1; n++) step;
        chk_val(12'(ila_running), 12'h001);
        for (int j = 0; j < 3 * MF; j++) begin
            n = j % MF;
            if (n == 0) chk_lane(OCT_K28_0, 1'b1);
            else if (n == MF - 1) chk_lane(OCT_K28_3, 1'b1);
            else chk_lane(8'(n), 1'b0);
            step;
        end
        resync = 1'b1;
        step;
        resync = 1'b0;
        for (n = 0; n < 4 && lane_k !== '1; n++) step;
        chk_lane(OCT_K28_5, 1'b1);
        chk_val(12'(ila_running), 12'h000);
        for (int m = 0; m < 3; m++) begin
            set_mode(fb_t[m], FMT_14, VAR_DUAL, 1'b1);
            repeat (3) begin step; chk_pass; end
        end
        results;
    end
endmodule // tb
